/* logic/adcpo_port.sv */
// What this block does
// - Each result appears as a 16-bit word, bit 15 most significant, bit 0 least.
// - Data-ready strobe is active low; a high-to-low edge announces each new word.
// - At decimation 8 the strobe runs four clocks high, four clocks low, continuously.
// - Each falling strobe edge is launched from a rising clock edge.
// - Bus word changes at the strobe falling edge; host samples only afterwards.
// - Bus is released whenever read enable or chip select is high.
// - Bus is driven only while both selects are low; host asserts both to read.
// - Power-down low shuts all circuitry except the reference enable and rate select outputs; an undriven pin reads as operating high.
// - Internal reference used while its enable is low; undriven pin reads as low.
// - Decimation rate follows the select input; undriven pin reads as low.
// - A dedicated output flag reports that the analog input is out of range.
// - Select low decimates by 8; select high decimates by 4, doubling word rate.
// - The over-range flag goes high whenever the input is over range and power-down is high.
// - While filter reset is low, strobe is forced high and the bus low.
// - Words are two's complement: 7fff at positive, 8000 at negative full scale.
`timescale 1ns/1ps
`default_nettype none
`include "adcpo_params.svh"

module adcpo_port
(
	// Clock and reset
	input  wire logic                     CORE_CLK_I,
	input  wire logic                     RST_I,
	// Device control pins
	input  wire logic                     FILTER_RESET_N_I,
	input  wire logic                     POWER_DOWN_N_I,
	input  wire logic                     INTERNAL_REF_ENABLE_N_I,
	input  wire logic                     DECIMATION_SELECT_I,
	// Host read strobes
	input  wire logic                     CHIP_SELECT_N_I,
	input  wire logic                     READ_ENABLE_N_I,
	// Words from the converter core
	input  wire logic                     SAMPLE_VALID_I,
	input  wire logic [`ADCPO_WORD_W-1:0] SAMPLE_CODE_I,
	input  wire logic                     SAMPLE_OVER_RANGE_I,
	output logic                          SAMPLE_READY_O,
	// Parallel sample bus
	output logic [`ADCPO_WORD_W-1:0]      SAMPLE_BUS_O,
	output logic                          SAMPLE_BUS_OE_O,
	output logic                          DATA_READY_STROBE_N_O,
	output logic                          OVER_RANGE_FLAG_O,
	// Controls toward the analog core
	output logic                          CORE_POWER_EN_O,
	output logic                          INTERNAL_REF_EN_O,
	output logic                          DECIMATE_BY4_O
);

	adcpo_pkg::adcpo_state_e state_reg, state_next;
	adcpo_pkg::adcpo_word_s  word_reg, word_next;
	adcpo_pkg::adcpo_word_s  push_word, head_word;
	logic [2:0]              phase_reg, phase_next;
	logic [2:0]              last_phase;
	logic                    strobe_reg, strobe_next;
	logic                    oe_reg, oe_next;
	logic                    otr_reg, otr_next;
	logic                    pwr_reg, pwr_next;
	logic                    ref_reg, ref_next;
	logic                    by4_reg, by4_next;
	logic                    run;
	logic                    fall;
	logic                    head_valid;
	logic                    fifo_ready;

	// The filter only runs while powered and out of filter reset.
	assign run             = FILTER_RESET_N_I & POWER_DOWN_N_I;
	assign last_phase      = (DECIMATION_SELECT_I ? `ADCPO_HALF_CYC_DEC4 : `ADCPO_HALF_CYC_DEC8) - 3'd1;
	assign fall            = run && (state_reg == adcpo_pkg::ST_HIGH) && (phase_reg >= last_phase);
	assign push_word.code  = SAMPLE_CODE_I;

	// Buffer lets the core run ahead of the strobe; a full buffer stalls the core.
	adcpo_fifo
	#(
		.WIDTH ($bits(adcpo_pkg::adcpo_word_s)),
		.DEPTH (`ADCPO_FIFO_DEPTH)
	)
	u_fifo
	(
		.clk_i       (CORE_CLK_I),
		.rst_i       (RST_I),
		.flush_i     (!run),
		.in_valid_i  (SAMPLE_VALID_I & run),
		.in_data_i   (push_word),
		.in_ready_o  (fifo_ready),
		.out_valid_o (head_valid),
		.out_data_o  (head_word),
		.out_ready_i (fall)
	);

	assign SAMPLE_READY_O = fifo_ready;

	always_comb
	begin
		state_next  = state_reg;
		phase_next  = phase_reg;
		word_next   = word_reg;
		strobe_next = strobe_reg;
		if (!run)
		begin
			state_next     = adcpo_pkg::ST_HOLD;
			phase_next     = 3'd0;
			strobe_next    = 1'b1;
			word_next.code = `ADCPO_WORD_RESET;
		end
		else
		begin
			unique case (state_reg)
				adcpo_pkg::ST_HOLD:
				begin
					state_next  = adcpo_pkg::ST_HIGH;
					phase_next  = 3'd0;
					strobe_next = 1'b1;
				end
				adcpo_pkg::ST_HIGH:
				begin
					if (fall)
					begin
						state_next  = adcpo_pkg::ST_LOW;
						phase_next  = 3'd0;
						strobe_next = 1'b0;
						// An empty buffer repeats the previous word rather than stop the strobe.
						if (head_valid)
							word_next = head_word;
					end
					else
						phase_next = phase_reg + 3'd1;
				end
				adcpo_pkg::ST_LOW:
				begin
					if (phase_reg >= last_phase)
					begin
						state_next  = adcpo_pkg::ST_HIGH;
						phase_next  = 3'd0;
						strobe_next = 1'b1;
					end
					else
						phase_next = phase_reg + 3'd1;
				end
				default:
				begin
					state_next  = adcpo_pkg::ST_HOLD;
					phase_next  = 3'd0;
					strobe_next = 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		oe_next  = !CHIP_SELECT_N_I && !READ_ENABLE_N_I && POWER_DOWN_N_I;
		otr_next = SAMPLE_OVER_RANGE_I & POWER_DOWN_N_I;
		pwr_next = POWER_DOWN_N_I;
		ref_next = !INTERNAL_REF_ENABLE_N_I;
		by4_next = DECIMATION_SELECT_I;
	end

	// Strobe and word are registered together so the edge leaves a rising clock edge.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			state_reg  <= adcpo_pkg::ST_HOLD;
			phase_reg  <= 3'd0;
			word_reg   <= '0;
			strobe_reg <= 1'b1;
			oe_reg     <= 1'b0;
			otr_reg    <= 1'b0;
			pwr_reg    <= 1'b0;
			ref_reg    <= 1'b0;
			by4_reg    <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			phase_reg  <= phase_next;
			word_reg   <= word_next;
			strobe_reg <= strobe_next;
			oe_reg     <= oe_next;
			otr_reg    <= otr_next;
			pwr_reg    <= pwr_next;
			ref_reg    <= ref_next;
			by4_reg    <= by4_next;
		end
	end

	assign SAMPLE_BUS_O          = word_reg.code;
	assign SAMPLE_BUS_OE_O       = oe_reg;
	assign DATA_READY_STROBE_N_O = strobe_reg;
	assign OVER_RANGE_FLAG_O     = otr_reg;
	assign CORE_POWER_EN_O       = pwr_reg;
	assign INTERNAL_REF_EN_O     = ref_reg;
	assign DECIMATE_BY4_O        = by4_reg;

	// Runs of steady conditions, so a change of select or reset disables the check.
	logic steady;
	assign steady = run && (DECIMATION_SELECT_I == by4_reg);

	sequence s_low_slow;
		(!strobe_reg && steady) [*4] ##1 strobe_reg;
	endsequence

	sequence s_high_slow;
		(strobe_reg && steady) [*4] ##1 !strobe_reg;
	endsequence

	sequence s_low_fast;
		(!strobe_reg && steady) [*2] ##1 strobe_reg;
	endsequence

	sequence s_high_fast;
		(strobe_reg && steady) [*2] ##1 !strobe_reg;
	endsequence

	property p_half(bit sel, bit lvl);
		@(posedge CORE_CLK_I) disable iff (RST_I || !steady || DECIMATION_SELECT_I != sel)
		(strobe_reg == lvl) && (strobe_reg != $past(strobe_reg)) && $past(state_reg) != adcpo_pkg::ST_HOLD;
	endproperty

	a_low_slow: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		($fell(strobe_reg) && !by4_reg && steady) |-> s_low_slow or ##[1:4] !steady)
		else $error("Strobe low phase is not four clocks at decimation 8.");

	a_high_slow: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		($rose(strobe_reg) && $past(state_reg) == adcpo_pkg::ST_LOW && !by4_reg && steady)
		|-> s_high_slow or ##[1:4] !steady)
		else $error("Strobe high phase is not four clocks at decimation 8.");

	a_low_fast: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		($fell(strobe_reg) && by4_reg && steady) |-> s_low_fast or ##[1:2] !steady)
		else $error("Strobe low phase is not two clocks at decimation 4.");

	a_high_fast: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		($rose(strobe_reg) && $past(state_reg) == adcpo_pkg::ST_LOW && by4_reg && steady)
		|-> s_high_fast or ##[1:2] !steady)
		else $error("Strobe high phase is not two clocks at decimation 4.");

	a_word_on_fall: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(fall && head_valid) |=> $fell(strobe_reg) && word_reg == $past(head_word))
		else $error("New word did not appear with the strobe falling edge.");

	a_word_held: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(run && !fall) |=> $stable(word_reg))
		else $error("Bus word changed away from a strobe falling edge.");

	a_bus_release: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(CHIP_SELECT_N_I || READ_ENABLE_N_I) |=> !SAMPLE_BUS_OE_O)
		else $error("Bus driven while a select is inactive.");

	a_bus_drive: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(!CHIP_SELECT_N_I && !READ_ENABLE_N_I && POWER_DOWN_N_I) |=> SAMPLE_BUS_OE_O)
		else $error("Bus not driven while both selects are active.");

	a_filter_reset: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!FILTER_RESET_N_I |=> DATA_READY_STROBE_N_O && SAMPLE_BUS_O == `ADCPO_WORD_RESET)
		else $error("Filter reset did not force strobe high and bus low.");

	a_over_range: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		(SAMPLE_OVER_RANGE_I && POWER_DOWN_N_I) |=> OVER_RANGE_FLAG_O)
		else $error("Over-range flag missed an over-range input.");

	a_power_down: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!POWER_DOWN_N_I |=> !CORE_POWER_EN_O && DATA_READY_STROBE_N_O && !SAMPLE_BUS_OE_O)
		else $error("Power down did not stop the block.");

	// Each pin copy is checked in both directions, so a stuck output cannot pass.
	a_power_up: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		POWER_DOWN_N_I |=> CORE_POWER_EN_O)
		else $error("Core power not enabled while the power-down pin is high.");

	a_ref_on: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!INTERNAL_REF_ENABLE_N_I |=> INTERNAL_REF_EN_O)
		else $error("Internal reference not enabled while its pin is low.");

	a_ref_off: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		INTERNAL_REF_ENABLE_N_I |=> !INTERNAL_REF_EN_O)
		else $error("Internal reference enabled while its pin is high.");

	a_rate_fast: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		DECIMATION_SELECT_I |=> DECIMATE_BY4_O)
		else $error("Decimation by four not selected while the select is high.");

	a_rate_slow: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!DECIMATION_SELECT_I |=> !DECIMATE_BY4_O)
		else $error("Decimation by four selected while the select is low.");

	a_range_clear: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!SAMPLE_OVER_RANGE_I |=> !OVER_RANGE_FLAG_O)
		else $error("Over-range flag high without an over-range input.");

endmodule // adcpo_port

`default_nettype wire

/* logic/adcpo_params.svh */
`ifndef ADCPO_PARAMS_SVH
`define ADCPO_PARAMS_SVH

// Width of one conversion word on the sample bus.
`define ADCPO_WORD_W          16
// Depth of the word buffer between converter core and sample bus.
`define ADCPO_FIFO_DEPTH      8
// Strobe half periods in clock cycles, per decimation setting.
`define ADCPO_HALF_CYC_DEC8   3'd4
`define ADCPO_HALF_CYC_DEC4   3'd2
// Value the sample bus shows while the filter is held in reset.
`define ADCPO_WORD_RESET      16'h0000
// Two's complement full-scale codes produced by the core.
`define ADCPO_CODE_POS_FULL   16'h7fff
`define ADCPO_CODE_NEG_FULL   16'h8000

`endif

/* logic/adcpo_pkg.sv */
`include "adcpo_params.svh"

package adcpo_pkg;

	typedef struct packed
	{
		logic [`ADCPO_WORD_W-1:0] code;
	} adcpo_word_s;

	typedef enum logic [2:0]
	{
		ST_HOLD = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW  = 3'b100
	} adcpo_state_e;

endpackage

/* logic/adcpo_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module adcpo_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	// Filling side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// Draining side
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg  [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             in_ready_reg, in_ready_next;
	logic             out_valid_reg, out_valid_next;
	logic             push, pop;

	assign push        = in_valid_i & in_ready_reg;
	assign pop         = out_ready_i & out_valid_reg;
	assign in_ready_o  = in_ready_reg;
	assign out_valid_o = out_valid_reg;
	assign out_data_o  = mem_reg[rd_reg];

	always_comb
	begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (flush_i)
		begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end
		else
		begin
			if (push)
			begin
				mem_next[wr_reg] = in_data_i;
				wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop)
				rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			if (push && !pop)
				cnt_next = cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_next = cnt_reg - 1'b1;
		end
		// Flags are registered so both ports come straight from flip-flops.
		in_ready_next  = (cnt_next != CW'(DEPTH));
		out_valid_next = (cnt_next != '0);
	end

	always_ff @(posedge clk_i)
	begin
		mem_reg <= mem_next;
		if (rst_i)
		begin
			wr_reg        <= '0;
			rd_reg        <= '0;
			cnt_reg       <= '0;
			in_ready_reg  <= 1'b0;
			out_valid_reg <= 1'b0;
		end
		else
		begin
			wr_reg        <= wr_next;
			rd_reg        <= rd_next;
			cnt_reg       <= cnt_next;
			in_ready_reg  <= in_ready_next;
			out_valid_reg <= out_valid_next;
		end
	end

	// Ready is held low through reset with an empty count, so the first cycle after release is skipped.
	a_fifo_bounds: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> cnt_reg <= CW'(DEPTH) && (in_ready_reg == (cnt_reg != CW'(DEPTH))))
		else $error("Buffer count out of range or ready flag wrong.");

	a_fifo_count: assert property (@(posedge clk_i) disable iff (rst_i)
		(!flush_i && push && !pop) |=> cnt_reg == $past(cnt_reg) + 1'b1)
		else $error("Buffer count did not grow on a lone write.");

endmodule // adcpo_fifo

`default_nettype wire

/* verif/adcpo_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module adcpo_host_model
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Read control from the bench
	input  wire logic        cs_en_i,
	input  wire logic        rd_en_i,
	// Device side
	input  wire logic        strobe_n_i,
	input  wire logic [15:0] bus_i,
	input  wire logic        oe_i,
	output logic             cs_n_o,
	output logic             rd_n_o,
	// Captured words
	output logic             cap_o,
	output logic [15:0]      word_o
);
	logic        strobe_q;
	logic [15:0] last_q;
	logic [15:0] seen;

	// The bus has no pull, so a released bus shows the inverse of the last value.
	assign seen = oe_i ? bus_i : ~last_q;

	always_ff @(posedge clk_i)
	begin
		cs_n_o   <= rst_i | ~cs_en_i;
		rd_n_o   <= rst_i | ~rd_en_i;
		strobe_q <= strobe_n_i;
		last_q   <= seen;
		// Sampling one cycle after the fall leaves the bus time to settle.
		cap_o    <= strobe_q & ~strobe_n_i & oe_i;
		word_o   <= seen;
	end
endmodule // adcpo_host_model

`default_nettype wire

/* verif/adcpo_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcpo_params.svh"

module adcpo_port_bench;
	typedef struct packed
	{
		logic        sel;
		logic [15:0] code;
		logic [2:0]  half;
	} adcpo_row_s;

	localparam adcpo_row_s ROWS [5] = '{
		'{1'b0, `ADCPO_CODE_POS_FULL, `ADCPO_HALF_CYC_DEC8},
		'{1'b0, `ADCPO_CODE_NEG_FULL, `ADCPO_HALF_CYC_DEC8},
		'{1'b1, 16'h0001, `ADCPO_HALF_CYC_DEC4},
		'{1'b1, 16'hfffe, `ADCPO_HALF_CYC_DEC4},
		'{1'b0, 16'ha5c3, `ADCPO_HALF_CYC_DEC8}};

	logic        clk, rst, filt_n, pd_n, ref_n, dsel, cs_n, rd_n, cs_en, rd_en;
	logic        s_valid, s_ovr, s_ready, oe, strobe_n, ovr_flag, pwr_en, ref_en, by4, cap;
	logic [15:0] s_code, bus, hword;
	logic [15:0] got_q [$];
	int          err_count, cmp_count;
	time         t_edge;

	adcpo_port dut (.CORE_CLK_I(clk), .RST_I(rst), .FILTER_RESET_N_I(filt_n), .POWER_DOWN_N_I(pd_n),
		.INTERNAL_REF_ENABLE_N_I(ref_n), .DECIMATION_SELECT_I(dsel), .CHIP_SELECT_N_I(cs_n),
		.READ_ENABLE_N_I(rd_n), .SAMPLE_VALID_I(s_valid), .SAMPLE_CODE_I(s_code),
		.SAMPLE_OVER_RANGE_I(s_ovr), .SAMPLE_READY_O(s_ready), .SAMPLE_BUS_O(bus), .SAMPLE_BUS_OE_O(oe),
		.DATA_READY_STROBE_N_O(strobe_n), .OVER_RANGE_FLAG_O(ovr_flag), .CORE_POWER_EN_O(pwr_en),
		.INTERNAL_REF_EN_O(ref_en), .DECIMATE_BY4_O(by4));

	adcpo_host_model host (.clk_i(clk), .rst_i(rst), .cs_en_i(cs_en), .rd_en_i(rd_en),
		.strobe_n_i(strobe_n), .bus_i(bus), .oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.cap_o(cap), .word_o(hword));

	always #50 clk = ~clk;

	always @(posedge clk) t_edge = $time;
	always @(posedge clk) if (cap === 1'b1) got_q.push_back(hword);
	always @(negedge strobe_n) if (rst === 1'b0) check_bit("fall_on_edge", 1'b1, $time == t_edge);

	task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_bit(input string name, input logic exp, input logic got);
		check_word(name, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic push(input logic [15:0] c);
		@(posedge clk);
		s_valid <= 1'b1;
		s_code  <= c;
		#1;
		for (int i = 0; i < 50 && s_ready !== 1'b1; i++)
			tick(1);
		@(posedge clk);
		s_valid <= 1'b0;
	endtask

	task automatic wait_word(input logic [15:0] exp);
		for (int i = 0; i < 60; i++)
		begin
			tick(1);
			if (cap === 1'b1 && hword === exp)
				break;
		end
		check_word("host_word", exp, hword);
	endtask

	task automatic measure(input logic [2:0] half);
		int lo, hi;
		lo = 0;
		hi = 0;
		for (int i = 0; i < 20 && strobe_n !== 1'b1; i++)
			tick(1);
		for (int i = 0; i < 20 && strobe_n !== 1'b0; i++)
			tick(1);
		while (strobe_n === 1'b0 && lo < 20)
		begin
			tick(1);
			lo++;
		end
		while (strobe_n === 1'b1 && hi < 20)
		begin
			tick(1);
			hi++;
		end
		check_word("low_len", 16'(half), 16'(lo));
		check_word("high_len", 16'(half), 16'(hi));
	endtask

	task automatic finish_test;
		$display("Compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#(100 * 5000);
		err_count++;
		finish_test;
	end

	initial
	begin
		int   n, k;
		logic r, full;
		n = 0;
		full = 1'b0;
		clk = 1'b0; rst = 1'b1; filt_n = 1'b1; pd_n = 1'b1; ref_n = 1'b0; dsel = 1'b0;
		s_valid = 1'b0; s_code = 16'h0000; s_ovr = 1'b0; cs_en = 1'b1; rd_en = 1'b1;
		tick(3);
		check_bit("reset_strobe", 1'b1, strobe_n);
		check_bit("reset_oe", 1'b0, oe);
		tick(2);
		@(posedge clk) rst <= 1'b0;
		foreach (ROWS[i])
		begin
			@(posedge clk) dsel <= ROWS[i].sel;
			tick(20);
			check_bit("by4", ROWS[i].sel, by4);
			push(ROWS[i].code);
			wait_word(ROWS[i].code);
			measure(ROWS[i].half);
		end
		@(posedge clk) s_ovr <= 1'b1;
		tick(1);
		check_bit("over_range", 1'b1, ovr_flag);
		@(posedge clk) s_ovr <= 1'b0;
		@(posedge clk) ref_n <= 1'b1;
		tick(1);
		check_bit("over_range", 1'b0, ovr_flag);
		check_bit("ref_en", 1'b0, ref_en);
		@(posedge clk) ref_n <= 1'b0;
		tick(1);
		check_bit("ref_en", 1'b1, ref_en);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) {cs_en, rd_en} <= 2'(i);
			tick(3);
			check_bit("bus_oe", i == 3, oe);
		end
		// Hold valid while the strobe drains one word per period, so the buffer must refuse.
		got_q.delete();
		@(posedge clk);
		s_valid <= 1'b1;
		s_code  <= 16'h0100;
		for (int i = 0; i < 14; i++)
		begin
			#1 r = s_ready;
			@(posedge clk);
			if (r === 1'b1)
			begin
				n++;
				s_code <= 16'h0100 + 16'(n);
			end
			else
				full = 1'b1;
		end
		s_valid <= 1'b0;
		check_bit("buffer_full", 1'b1, full);
		tick(96);
		k = 0;
		while (k < got_q.size() && got_q[k] !== 16'h0100)
			k++;
		for (int i = 0; i < n; i++)
			check_word("fifo_order", 16'h0100 + 16'(i), (k + i < got_q.size()) ? got_q[k + i] : 16'hxxxx);
		push(16'h5a5a);
		tick(20);
		@(posedge clk) filt_n <= 1'b0;
		tick(1);
		check_bit("fr_strobe", 1'b1, strobe_n);
		check_word("fr_bus", `ADCPO_WORD_RESET, bus);
		tick(10);
		check_bit("fr_hold", 1'b1, strobe_n);
		@(posedge clk) filt_n <= 1'b1;
		@(posedge clk) pd_n <= 1'b0;
		tick(2);
		check_bit("pwr_en", 1'b0, pwr_en);
		check_bit("pd_oe", 1'b0, oe);
		check_bit("pd_strobe", 1'b1, strobe_n);
		@(posedge clk) pd_n <= 1'b1;
		tick(2);
		check_bit("pwr_en", 1'b1, pwr_en);
		push(16'hc3a5);
		wait_word(16'hc3a5);
		finish_test;
	end
endmodule // adcpo_port_bench

`default_nettype wire
